// ==== fsr_pkg.sv ====
// Constants shared by the flash status register read block
package fsr_pkg;
	localparam logic [7:0] READ_STATUS_OPCODE = 8'h05;
	localparam int BIT_COUNT_WIDTH = 3;
	localparam logic [2:0] LAST_BIT_INDEX = 3'h7;

	// Byte one field positions
	localparam int B1_PROTECTION_LOCK = 7;
	localparam int B1_RESERVED = 6;
	localparam int B1_PROGRAM_ERASE_ERROR = 5;
	localparam int B1_PROTECT_PIN_STATE = 4;
	localparam int B1_SW_PROTECT_HI = 3;
	localparam int B1_SW_PROTECT_LO = 2;
	localparam int B1_WRITE_ENABLE_LATCH = 1;
	localparam int B1_READY_BUSY = 0;

	// Byte two field positions
	localparam int B2_RESET_COMMAND_ENABLE = 4;
	localparam int B2_LOCKDOWN_ENABLE = 3;
	localparam int B2_PROGRAM_SUSPENDED = 2;
	localparam int B2_ERASE_SUSPENDED = 1;
	localparam int B2_READY_BUSY = 0;

	// Software protection summary codes
	localparam logic [1:0] SWP_NONE = 2'h0;
	localparam logic [1:0] SWP_SOME = 2'h1;
	localparam logic [1:0] SWP_RESERVED = 2'h2;
	localparam logic [1:0] SWP_ALL = 2'h3;

	// Reset values
	localparam logic RST_PROTECTION_LOCK = 1'h0;
	localparam logic RST_PROGRAM_ERASE_ERROR = 1'h0;
	localparam logic RST_RESET_COMMAND_ENABLE = 1'h0;
	localparam logic RST_LOCKDOWN_ENABLE = 1'h0;
	localparam logic RST_LOCKDOWN_FROZEN = 1'h0;
	localparam logic [7:0] RST_STATUS_BYTE = 8'h00;

	// Serial engine states
	typedef enum logic [3:0] {
		SPI_IDLE = 4'h1,
		SPI_OPCODE = 4'h2,
		SPI_STREAM = 4'h4,
		SPI_IGNORE = 4'h8
	} fsr_spi_state_t;
endpackage : fsr_pkg

// ==== fsr_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module fsr_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stageOne;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			stageOne <= RESET_VALUE;
			syncOut <= RESET_VALUE;
		end else begin
			stageOne <= asyncIn;
			syncOut <= stageOne;
		end
	end
endmodule : fsr_sync

// ==== fsr_spi_engine.sv ====
// Serial engine: opcode capture and alternating status byte output
`timescale 1ns/1ps
module fsr_spi_engine (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic chipSelectSyncN,
	input wire logic serialClockSync,
	input wire logic serialInSync,
	input wire logic [7:0] statusByteOne,
	input wire logic [7:0] statusByteTwo,
	output logic serialOut,
	output logic serialOutEnable
);
	fsr_pkg::fsr_spi_state_t state, next_state;
	logic clockDelayed, next_clockDelayed;
	logic [7:0] shiftReg, next_shiftReg;
	logic [2:0] bitCount, next_bitCount;
	logic byteSel, next_byteSel;
	logic next_serialOut, next_serialOutEnable;
	logic rise, fall;
	logic [7:0] opcode;

	assign rise = serialClockSync & ~clockDelayed;
	assign fall = ~serialClockSync & clockDelayed;
	assign opcode = {shiftReg[6:0], serialInSync};

	always_comb begin
		next_state = state;
		next_clockDelayed = serialClockSync;
		next_shiftReg = shiftReg;
		next_bitCount = bitCount;
		next_byteSel = byteSel;
		next_serialOut = serialOut;
		next_serialOutEnable = serialOutEnable;
		if (chipSelectSyncN) begin
			// Deselect ends any transfer, even mid byte
			next_state = fsr_pkg::SPI_IDLE; // RL6
			next_serialOutEnable = 1'b0; // RL6
			next_serialOut = 1'b0;
			next_bitCount = '0;
		end else begin
			unique case (state)
				fsr_pkg::SPI_IDLE: begin
					next_state = fsr_pkg::SPI_OPCODE;
					next_bitCount = '0;
					if (rise) begin
						next_shiftReg = opcode;
						next_bitCount = 3'h1;
					end
				end
				fsr_pkg::SPI_OPCODE: begin
					if (rise) begin
						next_shiftReg = opcode;
						next_bitCount = bitCount + 3'h1;
						if (bitCount == fsr_pkg::LAST_BIT_INDEX) begin
							next_bitCount = '0;
							// Accepted regardless of busy state
							if (opcode == fsr_pkg::READ_STATUS_OPCODE) begin // RL1 RL4
								next_state = fsr_pkg::SPI_STREAM;
								next_shiftReg = statusByteOne; // RL3
								next_byteSel = 1'b1;
							end else begin
								next_state = fsr_pkg::SPI_IGNORE;
							end
						end
					end
				end
				fsr_pkg::SPI_STREAM: begin
					if (fall) begin
						// Most significant bit leads
						next_serialOut = shiftReg[7]; // RL24 RL1
						next_serialOutEnable = 1'b1;
						next_shiftReg = {shiftReg[6:0], 1'b0};
						next_bitCount = bitCount + 3'h1;
						if (bitCount == fsr_pkg::LAST_BIT_INDEX) begin
							// Reload with fresh contents, alternating bytes
							next_shiftReg = byteSel ? statusByteTwo : statusByteOne; // RL2 RL3
							next_byteSel = ~byteSel; // RL2
						end
					end
				end
				fsr_pkg::SPI_IGNORE: begin
					next_serialOutEnable = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= fsr_pkg::SPI_IDLE;
			clockDelayed <= 1'b0;
			shiftReg <= fsr_pkg::RST_STATUS_BYTE;
			bitCount <= '0;
			byteSel <= 1'b0;
			serialOut <= 1'b0;
			serialOutEnable <= 1'b0;
		end else begin
			state <= next_state;
			clockDelayed <= next_clockDelayed;
			shiftReg <= next_shiftReg;
			bitCount <= next_bitCount;
			byteSel <= next_byteSel;
			serialOut <= next_serialOut;
			serialOutEnable <= next_serialOutEnable;
		end
	end
endmodule : fsr_spi_engine

// ==== fsr_status_top.sv ====
// Two-byte flash status register with serial read-out
//
// Summary of operation
// RL1 - Opcode 05h starts status output each clock
// RL2 - Alternate byte one, byte two while selected
// RL3 - Contents refreshed; busy resampled every byte
// RL4 - Status read accepted even while busy
// RL5 - Host reads four bytes at high clock
// RL6 - Deselect ends read, output goes undriven
// RL7 - Lock bit blocks all sector protection changes
// RL8 - Lock clear at power-up, kept by reset
// RL9 - Pin asserted: lock may only be set
// RL10 - Byte one write changes only bit seven
// RL11 - Byte two write changes bits four, three
// RL12 - Error flag set on failed program/erase
// RL13 - Aborted operations never set the error flag; here opDone with opFailed in the same cycle as opAborted still sets it
// RL14 - Error flag rewritten at each operation end
// RL15 - Byte one bit four mirrors protect pin
// RL16 - Bits three:two summarise software protection
// RL17 - Bit one reports write enable latch
// RL18 - Bit zero of both bytes shows busy
// RL19 - Reset enable bit gates software reset
// RL20 - Lockdown enable gates lockdown and freeze
// RL21 - Suspend flags for program and erase
// RL22 - Reserved bits always read zero
// RL23 - Freeze forces lockdown enable to zero permanently
// RL24 - Each byte shifted most significant first
`timescale 1ns/1ps
module fsr_status_top (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic chipSelectN,
	input wire logic serialClock,
	input wire logic serialIn,
	input wire logic writeProtectN,
	output logic serialOut,
	output logic serialOutEnable,
	input wire logic deviceBusy,
	input wire logic writeEnableLatch,
	input wire logic [1:0] softwareProtectSummary,
	input wire logic programSuspended,
	input wire logic eraseSuspended,
	input wire logic opDone,
	input wire logic opAborted,
	input wire logic opFailed,
	input wire logic writeByteOne,
	input wire logic [7:0] writeByteOneData,
	input wire logic writeByteTwo,
	input wire logic [7:0] writeByteTwoData,
	input wire logic freezeLockdownDone,
	input wire logic softwareReset,
	output logic [7:0] statusByteOne,
	output logic [7:0] statusByteTwo,
	output logic protectCommandAllowed,
	output logic resetCommandAllowed,
	output logic lockdownCommandAllowed,
	output logic byteOneWriteRejected
);
	logic [3:0] pinsSync;
	logic chipSelectSyncN, serialClockSync, serialInSync, protectPinSync;
	logic protectionLock, next_protectionLock;
	logic programEraseError, next_programEraseError;
	logic resetCommandEnable, next_resetCommandEnable;
	logic lockdownEnable, next_lockdownEnable;
	logic lockdownFrozen, next_lockdownFrozen;
	logic [7:0] next_statusByteOne, next_statusByteTwo;
	logic next_protectCommandAllowed, next_resetCommandAllowed, next_lockdownCommandAllowed;
	logic next_byteOneWriteRejected;

	fsr_sync #(
		.WIDTH(4),
		.RESET_VALUE(4'hb)
	) pinSync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.asyncIn({chipSelectN, serialClock, serialIn, writeProtectN}),
		.syncOut(pinsSync)
	);

	assign chipSelectSyncN = pinsSync[3];
	assign serialClockSync = pinsSync[2];
	assign serialInSync = pinsSync[1];
	assign protectPinSync = pinsSync[0];

	fsr_spi_engine engine (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.chipSelectSyncN(chipSelectSyncN),
		.serialClockSync(serialClockSync),
		.serialInSync(serialInSync),
		.statusByteOne(statusByteOne),
		.statusByteTwo(statusByteTwo),
		.serialOut(serialOut),
		.serialOutEnable(serialOutEnable)
	);

	// Writable bits and sticky state; software reset deliberately touches none of it
	always_comb begin
		next_protectionLock = protectionLock; // RL8
		next_programEraseError = programEraseError;
		next_resetCommandEnable = resetCommandEnable;
		next_lockdownEnable = lockdownEnable;
		next_lockdownFrozen = lockdownFrozen;
		next_byteOneWriteRejected = 1'b0;
		if (writeByteOne) begin
			// Clearing the lock needs the pin deasserted
			if (!writeByteOneData[fsr_pkg::B1_PROTECTION_LOCK] && !protectPinSync
				&& protectionLock) begin // RL9
				next_byteOneWriteRejected = 1'b1;
			end else begin
				next_protectionLock = writeByteOneData[fsr_pkg::B1_PROTECTION_LOCK]; // RL10
			end
		end
		if (writeByteTwo) begin
			next_resetCommandEnable = writeByteTwoData[fsr_pkg::B2_RESET_COMMAND_ENABLE]; // RL11
			next_lockdownEnable = writeByteTwoData[fsr_pkg::B2_LOCKDOWN_ENABLE]; // RL11
		end
		if (freezeLockdownDone && lockdownEnable) begin
			next_lockdownFrozen = 1'b1; // RL23
		end
		if (next_lockdownFrozen) begin
			next_lockdownEnable = 1'b0; // RL23
		end
		// Completion rewrites the flag and wins over a same-cycle abort; an abort alone leaves it clear
		if (opDone) begin
			next_programEraseError = opFailed; // RL12 RL14
		end else if (opAborted) begin
			next_programEraseError = 1'b0; // RL13 RL14
		end
	end

	// Live status bytes, reloaded every cycle
	always_comb begin
		next_statusByteOne = fsr_pkg::RST_STATUS_BYTE; // RL22
		next_statusByteOne[fsr_pkg::B1_PROTECTION_LOCK] = protectionLock;
		next_statusByteOne[fsr_pkg::B1_PROGRAM_ERASE_ERROR] = programEraseError; // RL12
		next_statusByteOne[fsr_pkg::B1_PROTECT_PIN_STATE] = protectPinSync; // RL15
		next_statusByteOne[fsr_pkg::B1_SW_PROTECT_HI:fsr_pkg::B1_SW_PROTECT_LO] =
			softwareProtectSummary; // RL16
		next_statusByteOne[fsr_pkg::B1_WRITE_ENABLE_LATCH] = writeEnableLatch; // RL17
		next_statusByteOne[fsr_pkg::B1_READY_BUSY] = deviceBusy; // RL18
		next_statusByteTwo = fsr_pkg::RST_STATUS_BYTE; // RL22
		next_statusByteTwo[fsr_pkg::B2_RESET_COMMAND_ENABLE] = resetCommandEnable;
		next_statusByteTwo[fsr_pkg::B2_LOCKDOWN_ENABLE] = lockdownEnable;
		next_statusByteTwo[fsr_pkg::B2_PROGRAM_SUSPENDED] = programSuspended; // RL21
		next_statusByteTwo[fsr_pkg::B2_ERASE_SUSPENDED] = eraseSuspended; // RL21
		next_statusByteTwo[fsr_pkg::B2_READY_BUSY] = deviceBusy; // RL18
		next_protectCommandAllowed = ~protectionLock; // RL7
		next_resetCommandAllowed = resetCommandEnable; // RL19
		next_lockdownCommandAllowed = lockdownEnable; // RL20
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			protectionLock <= fsr_pkg::RST_PROTECTION_LOCK; // RL8
			programEraseError <= fsr_pkg::RST_PROGRAM_ERASE_ERROR;
			resetCommandEnable <= fsr_pkg::RST_RESET_COMMAND_ENABLE;
			lockdownEnable <= fsr_pkg::RST_LOCKDOWN_ENABLE;
			lockdownFrozen <= fsr_pkg::RST_LOCKDOWN_FROZEN;
			statusByteOne <= fsr_pkg::RST_STATUS_BYTE;
			statusByteTwo <= fsr_pkg::RST_STATUS_BYTE;
			protectCommandAllowed <= 1'b0;
			resetCommandAllowed <= 1'b0;
			lockdownCommandAllowed <= 1'b0;
			byteOneWriteRejected <= 1'b0;
		end else begin
			protectionLock <= next_protectionLock;
			programEraseError <= next_programEraseError;
			resetCommandEnable <= next_resetCommandEnable;
			lockdownEnable <= next_lockdownEnable;
			lockdownFrozen <= next_lockdownFrozen;
			statusByteOne <= next_statusByteOne;
			statusByteTwo <= next_statusByteTwo;
			protectCommandAllowed <= next_protectCommandAllowed;
			resetCommandAllowed <= next_resetCommandAllowed;
			lockdownCommandAllowed <= next_lockdownCommandAllowed;
			byteOneWriteRejected <= next_byteOneWriteRejected;
		end
	end
endmodule : fsr_status_top

// ==== fsr_status_chk.sv ====
// Port checker for the status register block
`timescale 1ns/1ps
module fsr_status_chk (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic chipSelectN,
	input wire logic writeProtectN,
	input wire logic serialOutEnable,
	input wire logic deviceBusy,
	input wire logic opDone,
	input wire logic opAborted,
	input wire logic opFailed,
	input wire logic writeByteOne,
	input wire logic [7:0] writeByteOneData,
	input wire logic writeByteTwo,
	input wire logic [7:0] writeByteTwoData,
	input wire logic freezeLockdownDone,
	input wire logic [7:0] statusByteOne,
	input wire logic [7:0] statusByteTwo,
	input wire logic protectCommandAllowed,
	input wire logic resetCommandAllowed,
	input wire logic lockdownCommandAllowed,
	input wire logic byteOneWriteRejected
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	property p_deselect; chipSelectN [*6] |-> !serialOutEnable; endproperty
	a_deselect: assert property (p_deselect) else $error("output driven after deselect");
	property p_reserved; 1'b1 |-> !statusByteOne[6] && statusByteTwo[7:5] == 3'h0; endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");
	property p_busy; 1'b1 |=> statusByteOne[0] == $past(deviceBusy)
		&& statusByteTwo[0] == $past(deviceBusy); endproperty
	a_busy: assert property (p_busy) else $error("busy flag wrong");
	property p_pin; $stable(writeProtectN) [*5] |-> statusByteOne[4] == writeProtectN; endproperty
	a_pin: assert property (p_pin) else $error("pin mirror wrong");
	property p_lockSet; writeByteOne && writeByteOneData[7] |-> ##2 statusByteOne[7]; endproperty
	a_lockSet: assert property (p_lockSet) else $error("lock not set");
	property p_allow; $past(reset_n) |-> protectCommandAllowed != statusByteOne[7]; endproperty
	a_allow: assert property (p_allow) else $error("protect gate wrong");
	property p_resetGate; $past(reset_n) |-> resetCommandAllowed == statusByteTwo[4]; endproperty
	a_resetGate: assert property (p_resetGate) else $error("reset gate wrong");
	property p_reject; byteOneWriteRejected |-> statusByteOne[7] ##2 statusByteOne[7]; endproperty
	a_reject: assert property (p_reject) else $error("lock cleared on refusal");
	property p_err; opDone |-> ##2 statusByteOne[5] == $past(opFailed, 2); endproperty
	a_err: assert property (p_err) else $error("error flag wrong after op");
	property p_abort; opAborted && !opDone |-> ##2 !statusByteOne[5]; endproperty
	a_abort: assert property (p_abort) else $error("error flag set on abort");
	property p_two; writeByteTwo |-> ##2 statusByteTwo[4] == $past(writeByteTwoData[4], 2); endproperty
	a_two: assert property (p_two) else $error("reset enable not written");
	property p_freeze; freezeLockdownDone && lockdownCommandAllowed
		|-> ##2 !lockdownCommandAllowed [*8]; endproperty
	a_freeze: assert property (p_freeze) else $error("lockdown enable after freeze");
endmodule : fsr_status_chk
bind fsr_status_top fsr_status_chk i_fsr_status_chk (.sys_clk, .reset_n, .chipSelectN,
	.writeProtectN, .serialOutEnable, .deviceBusy, .opDone, .opAborted, .opFailed, .writeByteOne,
	.writeByteOneData, .writeByteTwo, .writeByteTwoData, .freezeLockdownDone, .statusByteOne,
	.statusByteTwo, .protectCommandAllowed, .resetCommandAllowed, .lockdownCommandAllowed,
	.byteOneWriteRejected);

// ==== fsr_spi_host.sv ====
// Mode 0 serial host model that issues reads
`timescale 1ns/1ps
module fsr_spi_host (
	output logic chipSelectN,
	output logic serialClock,
	output logic serialIn,
	input wire logic serialOut,
	input wire logic serialOutEnable
);
	logic [31:0] got;
	event done;
	initial begin
		chipSelectN = 1'b1;
		serialClock = 1'b0;
		serialIn = 1'b0;
	end
	// Clock stands low between frames, 80 ns period
	task automatic xfer(input logic [7:0] op, input int n);
		got = 'x;
		chipSelectN = 1'b0;
		for (int i = 0; i < 8 + n; i++) begin
			serialIn = (i < 8) ? op[7 - i] : ~serialIn;
			#40 serialClock = 1'b1;
			if (i >= 8) got = {got[30:0], serialOutEnable ? serialOut : 1'bx};
			#40 serialClock = 1'b0;
		end
		#40 chipSelectN = 1'b1;
		serialIn = ~serialIn;
		#40 ->done;
		// Let the bench monitor take the result before a new frame clears it
		#4;
	endtask : xfer
endmodule : fsr_spi_host

// ==== tb.sv ====
// Self-checking bench for the status register block
`timescale 1ns/1ps
module tb;
	logic sys_clk, reset_n, chipSelectN, serialClock, serialIn, writeProtectN, serialOut;
	logic serialOutEnable, deviceBusy, writeEnableLatch, programSuspended, eraseSuspended;
	logic opDone, opAborted, opFailed, writeByteOne, writeByteTwo, freezeLockdownDone;
	logic softwareReset, protectCommandAllowed, resetCommandAllowed, lockdownCommandAllowed;
	logic byteOneWriteRejected, lock, err, reset_command_enable, lockdown_enable, frz;
	logic [1:0] softwareProtectSummary;
	logic [7:0] writeByteOneData, writeByteTwoData, statusByteOne, statusByteTwo, t;
	logic [31:0] r;
	logic [31:0] expQ[$];
	logic [15:0] steps[11] = '{16'h81ff, 16'h0300, 16'h8000, 16'h817f, 16'h41ff, 16'h2900,
		16'h1100, 16'h2900, 16'h2100, 16'h0500, 16'h41ff};
	int fail_count = 0;
	int compares = 0;
	int cyc = 0;
	fsr_status_top i_fsr_status_top (.sys_clk, .reset_n, .chipSelectN, .serialClock, .serialIn,
		.writeProtectN, .serialOut, .serialOutEnable, .deviceBusy, .writeEnableLatch,
		.softwareProtectSummary, .programSuspended, .eraseSuspended, .opDone, .opAborted,
		.opFailed, .writeByteOne, .writeByteOneData, .writeByteTwo, .writeByteTwoData,
		.freezeLockdownDone, .softwareReset, .statusByteOne, .statusByteTwo,
		.protectCommandAllowed, .resetCommandAllowed, .lockdownCommandAllowed,
		.byteOneWriteRejected);
	fsr_spi_host i_fsr_spi_host (.chipSelectN, .serialClock, .serialIn, .serialOut,
		.serialOutEnable);
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	function automatic logic [7:0] one(input logic b);
		return {lock, 1'b0, err, writeProtectN, softwareProtectSummary, writeEnableLatch, b};
	endfunction : one
	function automatic logic [7:0] two(input logic b);
		return {3'h0, reset_command_enable, lockdown_enable, programSuspended, eraseSuspended, b};
	endfunction : two
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task automatic rd(input logic [7:0] op, input int n, input logic [31:0] e);
		expQ.push_back(e);
		i_fsr_spi_host.xfer(op, n);
	endtask : rd
	task automatic rst;
		@(negedge sys_clk) reset_n = 1'b0;
		{lock, err, reset_command_enable, lockdown_enable, frz} = '0;
		repeat (3) @(negedge sys_clk);
		reset_n = 1'b1;
		repeat (3) @(negedge sys_clk);
	endtask : rst
	// Pulses one event group, updates the expected bits, then reads back
	task automatic ev(input logic [6:0] w, input logic [7:0] d);
		@(negedge sys_clk);
		{writeByteOne, writeByteTwo, opDone, opAborted, opFailed, freezeLockdownDone,
			softwareReset} = w;
		writeByteOneData = d;
		writeByteTwoData = d;
		if (w[6] && (d[7] || writeProtectN)) lock = d[7];
		if (w[5]) {reset_command_enable, lockdown_enable} = {d[4], d[3] && !frz};
		if (w[4]) err = w[2]; else if (w[3]) err = 1'b0;
		if (w[1] && lockdown_enable) {frz, lockdown_enable} = 2'h2;
		@(negedge sys_clk);
		{writeByteOne, writeByteTwo, opDone, opAborted, opFailed, freezeLockdownDone} = '0;
		softwareReset = 1'b0;
		repeat (3) @(negedge sys_clk);
		rd(8'h05, 16, {16'hxxxx, one(deviceBusy), two(deviceBusy)});
	endtask : ev
	always @(i_fsr_spi_host.done) begin
		compares++;
		if (expQ.size() == 0 || i_fsr_spi_host.got !== expQ[0]) begin
			fail_count++;
			$display("unexpected at %0t: read %h", $time, i_fsr_spi_host.got);
		end
		if (expQ.size() > 0) void'(expQ.pop_front());
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			print_verdict();
		end
	end
	initial begin
		{deviceBusy, writeEnableLatch, programSuspended, eraseSuspended, opDone} = '0;
		{opAborted, opFailed, writeByteOne, writeByteTwo, freezeLockdownDone} = '0;
		{softwareReset, softwareProtectSummary, writeByteOneData, writeByteTwoData} = '0;
		{writeProtectN, reset_n, r} = {1'b1, 1'b0, 32'h0000004c};
		rst();
		rd(8'h05, 32, {one(1'b0), two(1'b0), one(1'b0), two(1'b0)});
		$display("test reset done");
		for (int k = 0; k < 6; k++) begin
			r = xs(r);
			@(negedge sys_clk);
			{deviceBusy, writeEnableLatch, programSuspended, eraseSuspended, writeProtectN} = r[4:0];
			softwareProtectSummary = r[5] ? 2'h3 : {1'b0, r[6]};
			repeat (5) @(negedge sys_clk);
			rd(8'h05, 32, {2{one(deviceBusy), two(deviceBusy)}});
		end
		$display("test mirror done");
		@(negedge sys_clk) deviceBusy = 1'b1;
		repeat (3) @(negedge sys_clk);
		fork
			rd(8'h05, 32, {one(1'b1), two(1'b0), one(1'b0), two(1'b0)});
			begin
				repeat (250) @(negedge sys_clk);
				deviceBusy = 1'b0;
			end
		join
		$display("test busy done");
		foreach (steps[k]) begin
			@(negedge sys_clk) writeProtectN = steps[k][8];
			repeat (4) @(negedge sys_clk);
			ev(steps[k][15:9], steps[k][7:0]);
		end
		$display("test writes done");
		rd(8'h9f, 16, 32'hxxxx_xxxx);
		t = one(deviceBusy);
		rd(8'h05, 4, {28'hxxx_xxxx, t[7:4]});
		rst();
		rd(8'h05, 16, {16'hxxxx, one(deviceBusy), two(deviceBusy)});
		$display("test link done");
		repeat (20) @(negedge sys_clk);
		print_verdict();
	end
endmodule : tb
